/* File: src/status_pkg.sv */
package status_pkg;

    // ------------------------------------------------------------------
    // Register offsets (6-bit address field of the header byte)
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_RADIO_CONTROLLER_STATE  = 6'h35;
    localparam logic [5:0] ADDR_OUTPUT_PIN_PACKET_STAT  = 6'h38;
    localparam logic [5:0] ADDR_SYNTH_CAL_DAC_STATUS    = 6'h39;
    localparam logic [5:0] ADDR_TRANSMIT_FIFO_FILL      = 6'h3A;

    // ------------------------------------------------------------------
    // Header and field layout
    // ------------------------------------------------------------------
    localparam int         HDR_READ_BIT       = 7;
    localparam int         HDR_BURST_BIT      = 6;
    localparam int         STATE_CODE_WIDTH   = 5;
    localparam int         FIFO_COUNT_WIDTH   = 7;
    localparam int         DAC_WIDTH          = 8;
    localparam logic [2:0] LAST_BIT_INDEX     = 3'h7;
    localparam logic [7:0] UNMAPPED_READ      = 8'h00;
    localparam logic [7:0] REG_RESET_VALUE    = 8'h00;

    // ------------------------------------------------------------------
    // Controller state codes
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        sleep_code                   = 5'h00,
        idle_code                    = 5'h01,
        crystal_off_state            = 5'h02,
        oscillator_on_manual_cal     = 5'h03,
        regulator_on_manual_cal      = 5'h04,
        manual_calibration_state     = 5'h05,
        oscillator_on_state          = 5'h06,
        regulator_on_state           = 5'h07,
        calibration_start_state      = 5'h08,
        loop_bandwidth_boost_state   = 5'h09,
        synth_lock_state             = 5'h0A,
        converter_on_state           = 5'h0B,
        calibration_end_state        = 5'h0C,
        synth_on_for_transmit        = 5'h12,
        transmit_code                = 5'h13,
        transmit_end_code            = 5'h14,
        transmit_underflow_code      = 5'h16
    } controller_state_code_type;

    // Codes 13-17, 21 and 23-31 are never produced by the controller
    function automatic logic is_used_state_code(input logic [4:0] code);
        is_used_state_code = (code <= 5'h0C) ||
                             ((code >= 5'h12) && (code != 5'h15) &&
                              (code <= 5'h16));
    endfunction : is_used_state_code

endpackage : status_pkg

/* File: src/serial_pins_if.sv */
`timescale 1ns/1ps
interface serial_pins_if;
    logic sclk_rise;
    logic sclk_fall;
    logic si_bit;
    logic selected;

    modport producer (
        output sclk_rise,
        output sclk_fall,
        output si_bit,
        output selected
    );
    modport consumer (
        input  sclk_rise,
        input  sclk_fall,
        input  si_bit,
        input  selected
    );
endinterface : serial_pins_if

/* File: src/serial_pin_sync.sv */
`timescale 1ns/1ps
module serial_pin_sync (
    input  wire logic           clk_sys,
    input  wire logic           rstn,
    input  wire logic           sclk,
    input  wire logic           si,
    input  wire logic           csn,
    serial_pins_if.producer     pins
);
    // ------------------------------------------------------------------
    // Two-flop synchronisers; si and csn use only the second stage, sclk also a third
    // ------------------------------------------------------------------
    logic [2:0] sclk_meta;
    logic [1:0] si_meta;
    logic [1:0] csn_meta;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_meta <= 3'h0;
            si_meta   <= 2'h0;
            csn_meta  <= 2'h3;
        end
        else
        begin
            sclk_meta <= {sclk_meta[1:0], sclk};
            si_meta   <= {si_meta[0], si};
            csn_meta  <= {csn_meta[0], csn};
        end
    end

    // Edge taken between stage two and a delayed copy of it
    assign pins.sclk_rise = sclk_meta[1] & ~sclk_meta[2];
    assign pins.sclk_fall = ~sclk_meta[1] & sclk_meta[2];
    assign pins.si_bit    = si_meta[1];
    assign pins.selected  = ~csn_meta[1];
endmodule : serial_pin_sync

/* File: src/radio_tx_status_registers.sv */
`timescale 1ns/1ps
module radio_tx_status_registers
(
    input  wire logic                                  clk_sys,
    input  wire logic                                  rstn,
    input  wire logic                                  sclk,
    input  wire logic                                  si,
    input  wire logic                                  csn,
    output logic                                       so,
    output logic                                       so_oe_n,
    input  wire logic [status_pkg::STATE_CODE_WIDTH-1:0] controller_state_code,
    input  wire logic                                  general_output_pin0,
    input  wire logic                                  output_pin0_invert,
    input  wire logic [status_pkg::DAC_WIDTH-1:0]      synth_dac_setting,
    input  wire logic [status_pkg::FIFO_COUNT_WIDTH-1:0] tx_fifo_byte_count,
    input  wire logic                                  tx_fifo_underflow
);
    import status_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    serial_pins_if pins ();

    // Host clock must stay high and low for three system clocks;
    // shorter phases are lost in the synchronisers.
    serial_pin_sync u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .sclk    (sclk),
        .si      (si),
        .csn     (csn),
        .pins    (pins)
    );

    // ------------------------------------------------------------------
    // Status registers, refreshed every cycle from the live sources
    // No reset value is defined; zero is our own choice. Registers lag
    // the inputs by one clock, so a read sees the state just before
    // its last header rise.
    // ------------------------------------------------------------------
    logic [7:0] radio_controller_state;
    logic [7:0] output_pin_and_packet_status;
    logic [7:0] synth_calibration_dac_status;
    logic [7:0] transmit_fifo_fill_status;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            radio_controller_state <= REG_RESET_VALUE;
        else
            radio_controller_state <= {3'h0, controller_state_code};
    end

    // Pin input is taken after the output inverter; undoing it here
    // keeps the invert setting out of this bit.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            output_pin_and_packet_status <= REG_RESET_VALUE;
        else
            output_pin_and_packet_status <=
                {7'h00, general_output_pin0 ^ output_pin0_invert};
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            synth_calibration_dac_status <= REG_RESET_VALUE;
        else
            synth_calibration_dac_status <= synth_dac_setting;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            transmit_fifo_fill_status <= REG_RESET_VALUE;
        else
            transmit_fifo_fill_status <=
                {tx_fifo_underflow, tx_fifo_byte_count};
    end

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    // Status space needs both read and burst bits; anything else reads 0
    function automatic logic [7:0] read_value(input logic [7:0] header);
        read_value = UNMAPPED_READ;
        if (header[HDR_READ_BIT] && header[HDR_BURST_BIT])
        begin
            case (header[5:0])
                ADDR_RADIO_CONTROLLER_STATE:
                    read_value = radio_controller_state;
                ADDR_OUTPUT_PIN_PACKET_STAT:
                    read_value = output_pin_and_packet_status;
                ADDR_SYNTH_CAL_DAC_STATUS:
                    read_value = synth_calibration_dac_status;
                ADDR_TRANSMIT_FIFO_FILL:
                    read_value = transmit_fifo_fill_status;
                default:
                    read_value = UNMAPPED_READ;
            endcase
        end
    endfunction : read_value

    // ------------------------------------------------------------------
    // Serial access sequencer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        serial_idle   = 2'b00,
        serial_header = 2'b01,
        serial_data   = 2'b11
    } serial_state_type;

    serial_state_type serial_state;
    logic [2:0]       bit_index;
    logic [7:0]       shift_in;
    logic [7:0]       header;
    logic [7:0]       shift_out;
    logic [7:0]       next_shift_in;

    assign next_shift_in = {shift_in[6:0], pins.si_bit};

    // Frame phase; a deselect drops any partial byte
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            serial_state <= serial_idle;
        else if (!pins.selected)
            serial_state <= serial_idle;
        else
        begin
            case (serial_state)
                serial_idle:
                    serial_state <= serial_header;
                serial_header:
                begin
                    if (pins.sclk_rise && bit_index == LAST_BIT_INDEX)
                        serial_state <= serial_data;
                end
                serial_data:
                    serial_state <= serial_data;
                default:
                    serial_state <= serial_idle;
            endcase
        end
    end

    // Bit counter wraps at eight, so every byte ends on the same index
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            bit_index <= 3'h0;
            shift_in  <= 8'h00;
        end
        else if (!pins.selected || serial_state == serial_idle)
            bit_index <= 3'h0;
        else if (pins.sclk_rise)
        begin
            shift_in  <= next_shift_in;
            bit_index <= bit_index + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Header capture
    // ------------------------------------------------------------------
    // Kept for the whole frame so burst bytes re-read the same register
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            header <= 8'h00;
        else if (pins.selected && serial_state == serial_header &&
                 pins.sclk_rise && bit_index == LAST_BIT_INDEX)
            header <= next_shift_in;
    end

    // ------------------------------------------------------------------
    // Read data shifter
    // ------------------------------------------------------------------
    // Byte is loaded whole at the last header bit so a read is a
    // consistent snapshot; repeated bytes re-read the same register.
    // Written data bytes are shifted in and dropped: nothing is writable.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            shift_out <= 8'h00;
        else if (!pins.selected || serial_state == serial_idle)
            shift_out <= 8'h00;
        else if (pins.sclk_rise && bit_index == LAST_BIT_INDEX)
        begin
            if (serial_state == serial_header)
                shift_out <= read_value(next_shift_in);
            else
                shift_out <= read_value(header);
        end
        else if (pins.sclk_fall)
            shift_out <= {shift_out[6:0], 1'b0};
    end

    // ------------------------------------------------------------------
    // Serial output pin, changed on falling clock edges
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            so      <= 1'b0;
            so_oe_n <= 1'b1;
        end
        else if (!pins.selected)
        begin
            so      <= 1'b0;
            so_oe_n <= 1'b1;
        end
        else
        begin
            so_oe_n <= 1'b0;
            if (pins.sclk_fall)
                so <= shift_out[7];
        end
    end

endmodule : radio_tx_status_registers

/* File: verification/radio_tx_status_asserts.sv */
`timescale 1ns/1ps
module radio_tx_status_asserts (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic sclk,
    input  wire logic si,
    input  wire logic csn,
    input  wire logic so,
    input  wire logic so_oe_n
);
    logic       sclk_q;
    logic [7:0] hdr;
    logic [7:0] rises;
    logic       rise;
    logic [2:0] pos;
    logic       mapped;

    assign rise   = sclk && !sclk_q && !csn;
    assign pos    = rises[2:0];
    assign mapped = hdr inside {8'hF5, 8'hF8, 8'hF9, 8'hFA};

    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            sclk_q <= 1'b0;
        else
            sclk_q <= sclk;

    // Counts rises of the frame; deselect restarts the count
    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            rises <= 8'h00;
        else if (csn)
            rises <= 8'h00;
        else if (rise)
            rises <= rises + 8'h01;

    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            hdr <= 8'h00;
        else if (rise && rises < 8'h08)
            hdr <= {hdr[6:0], si};

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_data_bit;
        rise && rises >= 8'h08;
    endsequence
    sequence s_deselect;
        !csn ##1 csn;
    endsequence

    property p_state_reserved;
        s_data_bit ##0 (hdr == 8'hF5 && pos < 3'h3) |-> !so;
    endproperty
    property p_pin_reserved;
        s_data_bit ##0 (hdr == 8'hF8 && pos < 3'h7) |-> !so;
    endproperty
    property p_refused;
        s_data_bit ##0 !mapped |-> !so;
    endproperty
    property p_header_quiet;
        rise && rises < 8'h08 |-> !so;
    endproperty
    property p_released;
        csn[*6] |-> so_oe_n && !so;
    endproperty
    property p_driven;
        !csn[*6] |-> !so_oe_n;
    endproperty
    property p_steady;
        (sclk && !csn)[*6] |-> $stable(so);
    endproperty
    property p_release_time;
        s_deselect |-> ##[1:5] so_oe_n;
    endproperty

    a_state_reserved: assert property (p_state_reserved)
        else $error("state register reserved bit not zero");
    a_pin_reserved: assert property (p_pin_reserved)
        else $error("pin status reserved bit not zero");
    a_refused: assert property (p_refused)
        else $error("refused read returned a one");
    a_header_quiet: assert property (p_header_quiet)
        else $error("output not zero during header");
    a_released: assert property (p_released)
        else $error("output active while deselected");
    a_driven: assert property (p_driven)
        else $error("output not enabled while selected");
    a_steady: assert property (p_steady)
        else $error("output moved while clock high");
    a_release_time: assert property (p_release_time)
        else $error("enable not released after deselect");
endmodule : radio_tx_status_asserts

bind radio_tx_status_registers radio_tx_status_asserts chk_i (
    .clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .si(si), .csn(csn),
    .so(so), .so_oe_n(so_oe_n));

/* File: verification/serial_host_model.sv */
`timescale 1ns/1ps
module serial_host_model (
    input  wire logic clk_sys,
    input  wire logic so,
    output logic      sclk,
    output logic      si,
    output logic      csn
);
    // Half period of six system clocks: above the three the sync needs
    localparam int HALF = 6;
    logic       busy = 1'b0;
    logic [7:0] rx [$];

    initial
    begin
        sclk = 1'b0;
        si   = 1'b0;
        csn  = 1'b1;
    end

    // Idle data line keeps moving so no stale level passes as valid
    always @(posedge clk_sys)
        if (!busy)
            si <= ~si;

    // Register reads only, no lock polling on pin 0
    task automatic xfer(input logic [7:0] hdr, input int nb);
        logic [7:0] b;
        @(posedge clk_sys);
        busy <= 1'b1;
        csn  <= 1'b0;
        repeat (HALF) @(posedge clk_sys);
        for (int i = 7; i >= 0; i--)
        begin
            si <= hdr[i];
            repeat (HALF) @(posedge clk_sys);
            sclk <= 1'b1;
            repeat (HALF) @(posedge clk_sys);
            sclk <= 1'b0;
        end
        repeat (nb)
        begin
            for (int i = 7; i >= 0; i--)
            begin
                repeat (HALF) @(posedge clk_sys);
                b[i] = so;
                sclk <= 1'b1;
                repeat (HALF) @(posedge clk_sys);
                sclk <= 1'b0;
            end
            rx.push_back(b);
        end
        repeat (HALF) @(posedge clk_sys);
        csn  <= 1'b1;
        busy <= 1'b0;
        repeat (HALF) @(posedge clk_sys);
    endtask : xfer
endmodule : serial_host_model

/* File: verification/radio_tx_status_registers_tb.sv */
`timescale 1ns/1ps
module radio_tx_status_registers_tb;
    import status_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rstn    = 1'b0;
    logic        sclk, si, csn, so, so_oe_n;
    logic [4:0]  state   = 5'h01;
    logic        pin0    = 1'b0;
    logic        inv     = 1'b0;
    logic [7:0]  dac     = 8'h00;
    logic [6:0]  cnt     = 7'h00;
    logic        uf      = 1'b0;
    int          err_total = 0;
    int          n_checks  = 0;
    logic [4:0]  codes [15] = '{5'h01, 5'h03, 5'h04, 5'h05, 5'h06,
        5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h12, 5'h13, 5'h14,
        5'h16};
    logic [7:0]  hdrs [7] = '{8'hF5, 8'hF8, 8'hF9, 8'hFA, 8'h35, 8'hF6,
        8'h7A};

    always #20 clk_sys = ~clk_sys;

    radio_tx_status_registers dut (.clk_sys(clk_sys), .rstn(rstn),
        .sclk(sclk), .si(si), .csn(csn), .so(so), .so_oe_n(so_oe_n),
        .controller_state_code(state), .general_output_pin0(pin0),
        .output_pin0_invert(inv), .synth_dac_setting(dac),
        .tx_fifo_byte_count(cnt), .tx_fifo_underflow(uf));

    serial_host_model host (.clk_sys(clk_sys), .so(so), .sclk(sclk),
        .si(si), .csn(csn));

    // ------------------------------------------------------------
    // Reference model and checks
    // ------------------------------------------------------------
    function automatic int model(input int h);
        if (h < 192)
            return 0;
        case (h % 64)
            53: return state;
            56: return pin0 ^ inv;
            57: return dac;
            58: return uf * 128 + cnt;
            default: return 0;
        endcase
    endfunction : model

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (40000) @(posedge clk_sys);
        err_total++;
        give_verdict();
    end

    initial
    begin
        int          e;
        logic [31:0] rnd;
        void'($urandom(28631));
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        // Sleep and crystal-off are never read back
        foreach (codes[k])
        begin
            rnd = $urandom;
            @(posedge clk_sys);
            state <= codes[k];
            {pin0, inv, dac, cnt, uf} <= rnd[17:0];
            foreach (hdrs[j])
            begin
                host.xfer(hdrs[j], 1);
                e = model(hdrs[j]);
                chk(host.rx.pop_front(), e[7:0]);
            end
        end
        // Full count with underflow, cleared while the burst runs
        @(posedge clk_sys);
        cnt <= 7'h7F;
        uf  <= 1'b1;
        @(posedge clk_sys);
        fork
            host.xfer(8'hFA, 2);
            begin
                repeat (150) @(posedge clk_sys);
                cnt <= 7'h00;
                uf  <= 1'b0;
            end
        join
        chk(host.rx.pop_front(), 8'hFF);
        chk(host.rx.pop_front(), 8'h00);
        give_verdict();
    end
endmodule : radio_tx_status_registers_tb
